/* File: design/lar_register_bank.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Serial-bus reachable control registers of a 10-bit lens actuator
// Assumes: scl_i and sda_i are asynchronous pins, resynchronised here
// Notes:   SDA is open drain; sda_o is always low, sda_oe_o pulls the line
//////////////////////////////////////////////////////////////////////////////

// Functional notes
// - Master ack advances index, next register sent
// - Read without index starts at current index
// - Write increments index after each data byte
// - Eight-bit registers, unused bits read zero
// - Fields right justified, zeros on top
// - Bit 0 at 0x01 resets all registers
// - Range bit picks move offset 0x80 or 0x01
// - Three-bit step ratio at bits 4 to 2
// - Two-bit ringing mode at bits 1 to 0
// - Ring enable bit selects direct or ringing
// - Target code split over 0x04 and 0x05
// - Output moves only on low byte write or soft reset
// - Dead band split over 0x06, 0x07, default 0x10
// - Current index is last address plus one
// - Answer only slave address 0001 100
module lar_register_bank
#(
  parameter int unsigned TICK_CYCLES = lar_pkg::LAR_TICK_CYCLES
)
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [9:0] current_sink_output_o,
  output logic target_update_o,
  output logic ring_enable_o,
  output logic [1:0] ring_mode_o,
  output logic [2:0] step_ratio_o,
  output logic fast_resonance_offset_select_o,
  output logic [7:0] actuation_period_value_o,
  output logic [9:0] dead_band_o,
  output logic move_busy_o,
  output logic move_done_o
);
  import lar_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic scl_meta;
    logic scl_sync;
    logic scl_prev;
    logic sda_meta;
    logic sda_sync;
    logic sda_prev;
    lar_i2c_state_type state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic read_mode;
    logic want_index;
    logic [7:0] index;
    logic sda_drive;
    logic update;
    logic [9:0] applied_code;
    logic [LAR_NUM_REGS-1:0][7:0] regs;
  } lar_core_state_type;

  lar_core_state_type st;
  lar_core_state_type next_st;

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // True for an index that holds a register
  function automatic logic lar_index_valid(input logic [7:0] idx);
    lar_index_valid = (idx >= LAR_IDX_SOFT_RESET) && (idx <= LAR_IDX_BAND_LOW);
  endfunction

  // Read image of one register, zero elsewhere
  function automatic logic [7:0] lar_read_reg(input logic [LAR_NUM_REGS-1:0][7:0] regs,
                                              input logic [7:0] idx);
    if (lar_index_valid(idx))
    begin
      lar_read_reg = regs[idx[2:0]] & LAR_WRITE_MASKS[idx[2:0]];
    end
    else
    begin
      lar_read_reg = 8'h00;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus conditions from synchronised pins

  // Edges and start/stop from second and third flops only
  assign scl_rise = st.scl_sync && !st.scl_prev;
  assign scl_fall = !st.scl_sync && st.scl_prev;
  assign start_seen = st.scl_sync && st.scl_prev && st.sda_prev && !st.sda_sync;
  assign stop_seen = st.scl_sync && st.scl_prev && !st.sda_prev && st.sda_sync;
  assign rx_byte = {st.shreg[6:0], st.sda_sync};

  // Read image at the current index, for the transmitter
  assign tx_byte = lar_read_reg(st.regs, st.index);

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_st = st;
    next_st.update = 1'b0;

    // Two flops on each pin before any logic
    next_st.scl_meta = scl_i;
    next_st.scl_sync = st.scl_meta;
    next_st.scl_prev = st.scl_sync;
    next_st.sda_meta = sda_i;
    next_st.sda_sync = st.sda_meta;
    next_st.sda_prev = st.sda_sync;

    if (start_seen)
    begin
      // Start or repeated start: index is kept
      next_st.state = LAR_ST_ADDR;
      next_st.bit_cnt = 4'h0;
      next_st.sda_drive = 1'b0;
    end
    else if (stop_seen)
    begin
      next_st.state = LAR_ST_IDLE;
      next_st.sda_drive = 1'b0;
    end
    else
    begin
      case (st.state)
        LAR_ST_IDLE:
        begin
          next_st.sda_drive = 1'b0;
        end

        LAR_ST_ADDR:
        begin
          if (scl_rise)
          begin
            next_st.shreg = rx_byte;
            next_st.bit_cnt = st.bit_cnt + 4'h1;
            if (st.bit_cnt == 4'h7)
            begin
              if (rx_byte[7:1] == LAR_SLAVE_ADDR)
              begin
                next_st.read_mode = rx_byte[0];
                next_st.want_index = !rx_byte[0];
              end
              else
              begin
                next_st.state = LAR_ST_IDLE;
              end
            end
          end
          else if (scl_fall && (st.bit_cnt == 4'h8))
          begin
            next_st.state = LAR_ST_ACK;
            next_st.sda_drive = 1'b1;
          end
        end

        LAR_ST_RX:
        begin
          if (scl_rise)
          begin
            next_st.shreg = rx_byte;
            next_st.bit_cnt = st.bit_cnt + 4'h1;
            if (st.bit_cnt == 4'h7)
            begin
              if (st.want_index)
              begin
                next_st.index = rx_byte;
                next_st.want_index = 1'b0;
              end
              else
              begin
                next_st.index = st.index + 8'h01;
                if ((st.index == LAR_IDX_SOFT_RESET) && rx_byte[LAR_SOFTWARE_RESET_BIT_POS])
                begin
                  next_st.regs = LAR_RESET_VALUES;
                  next_st.applied_code = 10'h000;
                end
                else if (lar_index_valid(st.index))
                begin
                  next_st.regs[st.index[2:0]] = rx_byte & LAR_WRITE_MASKS[st.index[2:0]];
                  if (st.index == LAR_IDX_CODE_LOW)
                  begin
                    // Only the low byte launches a move
                    next_st.applied_code = {st.regs[LAR_IDX_CODE_HIGH[2:0]][1:0], rx_byte};
                    next_st.update = 1'b1;
                  end
                end
              end
            end
          end
          else if (scl_fall && (st.bit_cnt == 4'h8))
          begin
            next_st.state = LAR_ST_ACK;
            next_st.sda_drive = 1'b1;
          end
        end

        LAR_ST_ACK:
        begin
          if (scl_fall)
          begin
            next_st.bit_cnt = 4'h0;
            if (st.read_mode)
            begin
              // Reads start from the current index
              next_st.state = LAR_ST_TX;
              next_st.shreg = tx_byte;
              next_st.sda_drive = !tx_byte[7];
            end
            else
            begin
              next_st.state = LAR_ST_RX;
              next_st.sda_drive = 1'b0;
            end
          end
        end

        LAR_ST_TX:
        begin
          if (scl_fall)
          begin
            if (st.bit_cnt == 4'h7)
            begin
              next_st.sda_drive = 1'b0;
              next_st.state = LAR_ST_TX_ACK;
            end
            else
            begin
              next_st.shreg = {st.shreg[6:0], 1'b0};
              next_st.sda_drive = !st.shreg[6];
              next_st.bit_cnt = st.bit_cnt + 4'h1;
            end
          end
        end

        LAR_ST_TX_ACK:
        begin
          if (scl_rise)
          begin
            next_st.index = st.index + 8'h01;
            if (st.sda_sync)
            begin
              // Not acknowledged: wait for stop
              next_st.state = LAR_ST_IDLE;
            end
            else
            begin
              next_st.state = LAR_ST_TX_NEXT;
            end
          end
        end

        LAR_ST_TX_NEXT:
        begin
          if (scl_fall)
          begin
            next_st.state = LAR_ST_TX;
            next_st.bit_cnt = 4'h0;
            next_st.shreg = tx_byte;
            next_st.sda_drive = !tx_byte[7];
          end
        end

        default:
        begin
          next_st.state = LAR_ST_IDLE;
          next_st.sda_drive = 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st <= '0;
      st.scl_meta <= 1'b1;
      st.scl_sync <= 1'b1;
      st.scl_prev <= 1'b1;
      st.sda_meta <= 1'b1;
      st.sda_sync <= 1'b1;
      st.sda_prev <= 1'b1;
      st.state <= LAR_ST_IDLE;
      st.regs <= LAR_RESET_VALUES;
    end
    else
    begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Move timing

  lar_move_timer
  #(
    .TICK_CYCLES(TICK_CYCLES)
  )
  u_move_timer
  (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .start_i(st.update),
    .ring_enable_i(st.regs[LAR_IDX_CODE_HIGH[2:0]][LAR_RING_EN_POS]),
    .period_i(st.regs[LAR_IDX_PERIOD[2:0]]),
    .fast_select_i(st.regs[LAR_IDX_MODE[2:0]][LAR_FAST_SEL_POS]),
    .busy_o(move_busy_o),
    .done_o(move_done_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Outputs to the serial bus and the current sink logic

  // Open-drain data pin
  assign sda_o = 1'b0;
  assign sda_oe_o = st.sda_drive;

  // Register fields
  assign current_sink_output_o = st.applied_code;
  assign target_update_o = st.update;
  assign ring_enable_o = st.regs[LAR_IDX_CODE_HIGH[2:0]][LAR_RING_EN_POS];
  assign ring_mode_o = st.regs[LAR_IDX_MODE[2:0]][LAR_RING_MODE_LSB +: 2];
  assign step_ratio_o = st.regs[LAR_IDX_MODE[2:0]][LAR_STEP_RATIO_LSB +: 3];
  assign fast_resonance_offset_select_o = st.regs[LAR_IDX_MODE[2:0]][LAR_FAST_SEL_POS];
  assign actuation_period_value_o = st.regs[LAR_IDX_PERIOD[2:0]];
  assign dead_band_o = {st.regs[LAR_IDX_BAND_HIGH[2:0]][LAR_UPPER_LSB +: 2], st.regs[LAR_IDX_BAND_LOW[2:0]]};

endmodule

/* File: common/lar_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants for the lens actuator register bank
// Assumes: 40 MHz core clock, serial bus sampled by the core clock
// Notes:   Register images are indexed by register address
//////////////////////////////////////////////////////////////////////////////
package lar_pkg;

  // Serial bus slave address, 7 bits
  localparam logic [6:0] LAR_SLAVE_ADDR = 7'h0C;

  // Register indexes
  localparam logic [7:0] LAR_IDX_SOFT_RESET = 8'h01;
  localparam logic [7:0] LAR_IDX_MODE = 8'h02;
  localparam logic [7:0] LAR_IDX_PERIOD = 8'h03;
  localparam logic [7:0] LAR_IDX_CODE_HIGH = 8'h04;
  localparam logic [7:0] LAR_IDX_CODE_LOW = 8'h05;
  localparam logic [7:0] LAR_IDX_BAND_HIGH = 8'h06;
  localparam logic [7:0] LAR_IDX_BAND_LOW = 8'h07;
  localparam int LAR_NUM_REGS = 8;

  // Field positions
  localparam int LAR_SOFTWARE_RESET_BIT_POS = 0;
  localparam int LAR_FAST_SEL_POS = 5;
  localparam int LAR_STEP_RATIO_LSB = 2;
  localparam int LAR_RING_MODE_LSB = 0;
  localparam int LAR_RING_EN_POS = 2;
  localparam int LAR_UPPER_LSB = 0;

  // Ringing mode codes
  localparam logic [1:0] LAR_MODE_RES_ONE = 2'h0;
  localparam logic [1:0] LAR_MODE_RES_HALF = 2'h1;
  localparam logic [1:0] LAR_MODE_RES_TWO = 2'h2;
  localparam logic [1:0] LAR_MODE_SLOPE = 2'h3;

  // Move-time offsets chosen by the fast resonance select bit
  localparam logic [8:0] LAR_OFFSET_SLOW = 9'h080;
  localparam logic [8:0] LAR_OFFSET_FAST = 9'h001;

  // Reset values and writable masks, index 7 down to index 0
  localparam logic [LAR_NUM_REGS-1:0][7:0] LAR_RESET_VALUES =
    {8'h10, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
  localparam logic [LAR_NUM_REGS-1:0][7:0] LAR_WRITE_MASKS =
    {8'hFF, 8'h03, 8'hFF, 8'h07, 8'hFF, 8'h3F, 8'h01, 8'h00};

  // Move-time tick of 51.2 us in core clock cycles
  localparam int LAR_CLK_PERIOD_NS = 25;
  localparam int LAR_TICK_NS = 51200;
  localparam int LAR_TICK_CYCLES = (LAR_TICK_NS + LAR_CLK_PERIOD_NS - 1) / LAR_CLK_PERIOD_NS;

  // Serial bus slave states
  typedef enum logic [2:0] {
    LAR_ST_IDLE,
    LAR_ST_ADDR,
    LAR_ST_RX,
    LAR_ST_ACK,
    LAR_ST_TX,
    LAR_ST_TX_ACK,
    LAR_ST_TX_NEXT
  } lar_i2c_state_type;

endpackage

/* File: design/lar_move_timer.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Counts the actuation time of one move in 51.2 us ticks
// Assumes: start_i is a one-cycle pulse from the register bank
// Notes:   Direct load finishes in the cycle after the start pulse
//////////////////////////////////////////////////////////////////////////////
module lar_move_timer
#(
  parameter int unsigned TICK_CYCLES = lar_pkg::LAR_TICK_CYCLES
)
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic ring_enable_i,
  input wire logic [7:0] period_i,
  input wire logic fast_select_i,
  output logic busy_o,
  output logic done_o
);
  import lar_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic busy;
    logic done;
    logic [TW-1:0] tick_cnt;
    logic [8:0] ticks_left;
  } lar_timer_state_type;

  lar_timer_state_type st;
  lar_timer_state_type next_st;

  // Tick prescaler and move countdown
  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    if (start_i)
    begin
      next_st.tick_cnt = '0;
      if (ring_enable_i)
      begin
        next_st.busy = 1'b1;
        next_st.ticks_left = {1'b0, period_i} + (fast_select_i ? LAR_OFFSET_FAST : LAR_OFFSET_SLOW);
      end
      else
      begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
    else if (st.busy)
    begin
      if (st.tick_cnt == TICK_LAST)
      begin
        next_st.tick_cnt = '0;
        if (st.ticks_left == 9'h001)
        begin
          next_st.busy = 1'b0;
          next_st.done = 1'b1;
        end
        else
        begin
          next_st.ticks_left = st.ticks_left - 9'h001;
        end
      end
      else
      begin
        next_st.tick_cnt = st.tick_cnt + TW'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign busy_o = st.busy;
  assign done_o = st.done;

endmodule

/* File: verification/lar_props.sv */
////////////////////////////////////////
// Purpose: Port checks of the lens actuator register bank
// Assumes: Bound to the top module
// Notes:   Move length counted in helper logic
////////////////////////////////////////
module lar_props
#(
  parameter int unsigned TICK_CYCLES = 4
)
(
  input logic clk_sys_i,
  input logic reset_n_i,
  input logic scl_i,
  input logic sda_i,
  input logic sda_o,
  input logic sda_oe_o,
  input logic [9:0] current_sink_output_o,
  input logic target_update_o,
  input logic ring_enable_o,
  input logic [1:0] ring_mode_o,
  input logic [2:0] step_ratio_o,
  input logic fast_resonance_offset_select_o,
  input logic [7:0] actuation_period_value_o,
  input logic [9:0] dead_band_o,
  input logic move_busy_o,
  input logic move_done_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dc @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic [31:0] bcnt;
  logic [31:0] blen;

  // Busy cycles and expected move length, taken at each update
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      bcnt <= 32'h0000_0000;
      blen <= 32'h0000_0000;
    end
    else if (target_update_o)
    begin
      bcnt <= 32'h0000_0000;
      blen <= TICK_CYCLES * (32'(actuation_period_value_o)
              + (fast_resonance_offset_select_o ? 32'h0000_0001 : 32'h0000_0080));
    end
    else if (move_busy_o)
      bcnt <= bcnt + 32'h0000_0001;

  ////////////////////////////////////////
  a_sink_on_update:
    assert property ($changed(current_sink_output_o) |-> target_update_o || current_sink_output_o == 10'h000)
    else $error("Sink changed without update");
  a_update_one_cycle:
    assert property (target_update_o |=> !target_update_o)
    else $error("Update pulse too long");
  a_direct_done:
    assert property (target_update_o && !ring_enable_o |=> move_done_o)
    else $error("Direct load not done");
  a_ring_starts:
    assert property (target_update_o && ring_enable_o |=> move_busy_o)
    else $error("Ringing move not started");
  a_move_length:
    assert property ($fell(move_busy_o) |-> bcnt == blen)
    else $error("Move length wrong");
  a_done_one_cycle:
    assert property (move_done_o |=> !move_done_o)
    else $error("Done pulse too long");
  a_sda_scl_low:
    assert property ($changed(sda_oe_o) |-> !$past(scl_i))
    else $error("Data line moved while clock high");
  a_reg_on_bit:
    assert property ($changed({dead_band_o, actuation_period_value_o, ring_mode_o, step_ratio_o,
      fast_resonance_offset_select_o, ring_enable_o}) |-> $past(scl_i))
    else $error("Register changed off a clock high");
endmodule

/* File: verification/lar_i2c_master.sv */
////////////////////////////////////////
// Purpose: Serial bus master model for the register bank
// Assumes: Data line pulled up; high output releases it
// Notes:   Clock low and high 4 core clocks each, 200 ns bus period
////////////////////////////////////////
module lar_i2c_master
(
  input logic clk_i,
  input logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus, clock stands still high
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Half bus period
  task automatic hp;
    repeat (4) @(posedge clk_i);
  endtask

  // Start or repeated start, clock left low
  task automatic st;
    sda_o <= 1'b1;
    hp;
    scl_o <= 1'b1;
    hp;
    sda_o <= 1'b0;
    hp;
    scl_o <= 1'b0;
    hp;
  endtask

  // Stop condition
  task automatic sp;
    sda_o <= 1'b0;
    hp;
    scl_o <= 1'b1;
    hp;
    sda_o <= 1'b1;
    hp;
  endtask

  // One bit: set mid clock low, sampled at the end of clock high
  task automatic bt(input logic b, output logic r);
    sda_o <= b;
    repeat (2) @(posedge clk_i);
    scl_o <= 1'b1;
    hp;
    r = sda_i;
    scl_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // Byte out, MSB first, then the acknowledge slot
  task automatic wb(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], r);
    bt(1'b1, nak);
  endtask

  // Byte in, then our acknowledge or not
  task automatic rb(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
    bt(last, r);
  endtask

  // Write: address, index, data bytes, stop
  task automatic wr(input logic [7:0] idx, input logic [7:0] q [$], output int naks);
    logic n;
    naks = 0;
    st;
    wb(8'h18, n);
    naks += n;
    wb(idx, n);
    naks += n;
    foreach (q[i])
    begin
      wb(q[i], n);
      naks += n;
    end
    sp;
  endtask

  // Read: index write and repeated start unless idx is negative
  task automatic rd(input int idx, input int cnt, output logic [7:0] q [$], output int naks);
    logic n;
    logic [7:0] d;
    naks = 0;
    q = {};
    st;
    if (idx >= 0)
    begin
      wb(8'h18, n);
      naks += n;
      wb(8'(idx), n);
      naks += n;
      st;
    end
    wb(8'h19, n);
    naks += n;
    for (int i = 0; i < cnt; i++)
    begin
      rb(i == cnt - 1, d);
      q.push_back(d);
    end
    sp;
  endtask
endmodule

/* File: verification/tb_lar_register_bank.sv */
////////////////////////////////////////
// Purpose: Self-checking bench of the lens actuator register bank
// Assumes: Master model drives the pins, data line pulled up
// Notes:   Move tick shortened to 4 clocks
////////////////////////////////////////
module tb_lar_register_bank;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned TICK = 4;
  localparam logic [7:0] def_val [8] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h10};
  localparam logic [7:0] wr_mask [8] = '{8'h00, 8'h01, 8'h3F, 8'hFF, 8'h07, 8'hFF, 8'h03, 8'hFF};
  logic clk_sys_i;
  logic reset_n_i;
  logic scl_i;
  logic sda_m;
  logic sda_o;
  logic sda_oe_o;
  logic [9:0] current_sink_output_o;
  logic target_update_o;
  logic ring_enable_o;
  logic [1:0] ring_mode_o;
  logic [2:0] step_ratio_o;
  logic fast_resonance_offset_select_o;
  logic [7:0] actuation_period_value_o;
  logic [9:0] dead_band_o;
  logic move_busy_o;
  logic move_done_o;
  logic nk;
  logic [7:0] q [$];
  logic [7:0] mr [8];
  logic [9:0] msink;
  int fails = 0;
  int checks = 0;
  int idx;
  int n;
  int k;
  // Open-drain data line, both parties and pull-up
  wire sda_i = sda_m & (sda_oe_o ? sda_o : 1'b1);

  lar_register_bank #(.TICK_CYCLES(TICK)) uut (.clk_sys_i, .reset_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
    .current_sink_output_o, .target_update_o, .ring_enable_o, .ring_mode_o, .step_ratio_o,
    .fast_resonance_offset_select_o, .actuation_period_value_o, .dead_band_o, .move_busy_o, .move_done_o);
  lar_i2c_master mst (.clk_i(clk_sys_i), .sda_i(sda_i), .scl_o(scl_i), .sda_o(sda_m));

  // 40 MHz core clock
  initial clk_sys_i = 1'b0;
  always #12.5 clk_sys_i = ~clk_sys_i;

  ////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Model: defaults, masked writes, soft reset, index step
  task automatic mres;
    mr = def_val;
    msink = 10'h000;
  endtask

  task automatic mwr(input logic [7:0] d);
    if (idx == 1 && d[0]) mres;
    else if (idx >= 1 && idx <= 7) mr[idx] = d & wr_mask[idx];
    if (idx == 5) msink = {mr[4][1:0], d};
    idx = (idx + 1) % 256;
  endtask

  // Outputs against the model
  task automatic chk;
    cmp(current_sink_output_o, msink, "sink");
    cmp(ring_mode_o, mr[2][1:0], "mode");
    cmp(step_ratio_o, mr[2][4:2], "ratio");
    cmp(fast_resonance_offset_select_o, mr[2][5], "fast");
    cmp(actuation_period_value_o, mr[3], "period");
    cmp(ring_enable_o, mr[4][2], "ring");
    cmp(dead_band_o, {mr[6][1:0], mr[7]}, "band");
  endtask

  // Write after any move has ended
  task automatic twr(input logic [7:0] i, input logic [7:0] d [$]);
    int nv;
    int w;
    for (w = 0; w < 2000 && move_busy_o !== 1'b0; w++) @(posedge clk_sys_i);
    cmp(move_busy_o, 0, "busy");
    if (move_busy_o !== 1'b0) end_sim;
    mst.wr(i, d, nv);
    cmp(nv, 0, "ack");
    idx = i;
    foreach (d[j]) mwr(d[j]);
    chk;
  endtask

  task automatic trd(input int i, input int cnt);
    logic [7:0] rq [$];
    int nv;
    mst.rd(i, cnt, rq, nv);
    cmp(nv, 0, "ack");
    if (i >= 0) idx = i;
    foreach (rq[j])
    begin
      cmp(rq[j], (idx >= 1 && idx <= 7) ? mr[idx] : 8'h00, "read");
      idx = (idx + 1) % 256;
    end
  endtask

  ////////////////////////////////////////
  initial
  begin
    reset_n_i = 1'b0;
    void'($urandom(32'h25b1_fb03));
    mres;
    idx = 0;
    repeat (12) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk;
    trd(-1, 9);
    twr(8'h03, {8'hCA});
    trd(-1, 2);
    twr(8'h01, {8'hFE});
    twr(8'h06, {8'hFF, 8'h3C});
    twr(8'h01, {8'h01, 8'hFF});
    trd(1, 7);
    // Every mode, ratio and offset, each with a timed move
    for (int i = 0; i < 8; i++)
      twr(8'h02, {{2'b11, i[0], i[2:0], i[1:0]}, 8'($urandom), {5'h1F, 3'($urandom) | 3'h4},
        8'($urandom)});
    twr(8'h04, {8'h02, 8'h5A});
    twr(8'h04, {8'h01});
    // Foreign address is left alone
    mst.st;
    mst.wb(8'h1A, nk);
    cmp(nk, 1, "nak");
    mst.wb(8'h05, nk);
    mst.sp;
    chk;
    // Random mix of writes and reads
    repeat (12)
    begin
      n = 1 + $urandom % 4;
      k = $urandom % 10;
      case ($urandom % 3)
        0:
        begin
          q = {};
          repeat (n) q.push_back(8'($urandom));
          twr(8'(k), q);
        end
        1: trd(k, n);
        default: trd(-1, n);
      endcase
    end
    end_sim;
  end
endmodule

bind lar_register_bank lar_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.clk_sys_i, .reset_n_i, .scl_i, .sda_i,
  .sda_o, .sda_oe_o, .current_sink_output_o, .target_update_o, .ring_enable_o, .ring_mode_o, .step_ratio_o,
  .fast_resonance_offset_select_o, .actuation_period_value_o, .dead_band_o, .move_busy_o, .move_done_o);
